/* File: rtl/trm_pkg.sv */
// Constants and types shared by the trigger routing matrix files.
`default_nettype none
package trm_pkg;
	////////////////////////////////////////////////////////////////////////
	// Register byte offsets.
	localparam logic [7:0] TRM_CFG_OFF = 8'h00;
	localparam logic [7:0] TRM_CMD_OFF = 8'h04;
	localparam logic [7:0] TRM_STAT_OFF = 8'h08;
	localparam logic [31:0] TRM_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] TRM_ZERO = 32'h0000_0000;
	localparam int TRM_CFG_W = 11;
	////////////////////////////////////////////////////////////////////////
	// Configuration fields: one two-bit route setting per pairing, then single-bit analyzer and break enables for line B.
	localparam int TRM_NPAIR = 4;
	localparam int TRM_PAIR_COAX_A = 0;
	localparam int TRM_PAIR_COAX_B = 1;
	localparam int TRM_PAIR_BUS_A = 2;
	localparam int TRM_PAIR_BUS_B = 3;
	localparam int TRM_ANA_DRV_B_BIT = 8;
	localparam int TRM_ANA_RCV_B_BIT = 9;
	localparam int TRM_BRK_B_BIT = 10;
	localparam logic [1:0] TRM_ROUTE_NONE = 2'h0;
	localparam logic [1:0] TRM_ROUTE_DRIVE = 2'h1;
	localparam logic [1:0] TRM_ROUTE_RECEIVE = 2'h2;
	////////////////////////////////////////////////////////////////////////
	// Command bits, write-one pulses.
	localparam int TRM_CMD_ARM_BIT = 0;
	localparam int TRM_CMD_EXEC_BIT = 1;
	localparam int TRM_CMD_BREAK_BIT = 2;
	////////////////////////////////////////////////////////////////////////
	// Status bits.
	localparam int TRM_ST_MONITOR_BIT = 0;
	localparam int TRM_ST_ARMED_BIT = 1;
	localparam int TRM_ST_RUNNING_BIT = 2;
	localparam int TRM_ST_WAIT_BIT = 3;
	localparam int TRM_ST_LINE_A_BIT = 4;
	localparam int TRM_ST_LINE_B_BIT = 5;
	localparam int TRM_ST_READY_BIT = 6;
	////////////////////////////////////////////////////////////////////////
	// Run handshake states.
	typedef enum logic [1:0] {
		TRM_MONITOR,
		TRM_ARMED,
		TRM_RUNNING,
		TRM_WAIT_READY
	} trm_run_e;
endpackage : trm_pkg
`default_nettype wire

/* File: rtl/trm_run_ctl.sv */
// Coordination bus run handshake of one emulator.
`default_nettype none
module trm_run_ctl
	import trm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic arm_req,
	input wire logic exec_seen,
	input wire logic bus_ready,
	input wire logic break_req,
	output trm_run_e state_r,
	output logic start_r,
	output logic stop_r,
	output logic ready_hold_r
);
	////////////////////////////////////////////////////////////////////////
	// State transitions.
	trm_run_e state_nxt;
	logic ready_d_r;
	wire ready_rise = bus_ready & ~ready_d_r;
	wire ready_fall = ~bus_ready & ready_d_r;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			TRM_MONITOR: begin
				if (arm_req && !break_req) begin
					state_nxt = TRM_ARMED;
				end
			end
			TRM_ARMED: begin
				if (break_req) begin
					state_nxt = TRM_MONITOR;
				end else if (bus_ready && exec_seen) begin
					state_nxt = TRM_RUNNING;
				end
			end
			TRM_RUNNING: begin
				if (break_req) begin
					state_nxt = TRM_MONITOR;
				end else if (ready_fall) begin
					state_nxt = TRM_WAIT_READY;
				end
			end
			TRM_WAIT_READY: begin
				if (break_req) begin
					state_nxt = TRM_MONITOR;
				end else if (ready_rise) begin
					state_nxt = TRM_RUNNING;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= TRM_MONITOR;
			ready_d_r <= 1'b0;
			start_r <= 1'b0;
			stop_r <= 1'b0;
			ready_hold_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			ready_d_r <= bus_ready;
			start_r <= (state_nxt == TRM_RUNNING) && (state_r != TRM_RUNNING);
			stop_r <= (state_r == TRM_RUNNING) && (state_nxt != TRM_RUNNING);
			ready_hold_r <= (state_nxt == TRM_MONITOR);
		end
	end
endmodule : trm_run_ctl
`default_nettype wire

/* File: rtl/trm_matrix.sv */
// Trigger routing matrix with coordination bus run control and APB registers.
// Behaviour
// - Analyzer takes its trigger from line B when configured to receive it.
// - Analyzer trigger input never selects line A.
// - Each external/internal pairing is drive, receive or none; reset is none.
// - A trigger source on a received line breaks the emulator into monitor.
// - Break input has an enable for line B, including bus cross trigger.
// - Break input always listens to line A, no enable.
// - Coax set to drive line A breaks the emulator on assertion.
// - Armed emulator starts only with bus ready and the run strobe.
// - Ready is held off by every participant until it is armed.
// - Any participant may strobe run; emulator and analyzer start together.
// - A break on any participant stops every participant.
// - Analyzer always drives line A on its trigger.
//
// Added by the designer: the APB slave port and the placing of the registers.
`default_nettype none
module trm_matrix
	import trm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic analyzer_trigger_found,
	output logic analyzer_trigger_in,
	output logic analyzer_start,
	output logic emulator_break,
	output logic emulator_start,
	output logic emulator_running,
	input wire logic coax_trigger_line_i,
	output logic coax_trigger_line_o,
	output logic coax_trigger_line_oe,
	input wire logic bus_cross_trigger_i,
	output logic bus_cross_trigger_o,
	output logic bus_cross_trigger_oe,
	input wire logic bus_ready_i,
	output logic bus_ready_o,
	output logic bus_ready_oe,
	input wire logic bus_execute_i,
	output logic bus_execute_o,
	output logic bus_execute_oe
);
	////////////////////////////////////////////////////////////////////////
	// APB decode.
	logic [TRM_CFG_W-1:0] cfg_r;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	wire setup = psel & ~penable & ~pready_r;
	wire hit_cfg = (paddr == TRM_CFG_OFF);
	wire hit_cmd = (paddr == TRM_CMD_OFF);
	wire hit_stat = (paddr == TRM_STAT_OFF);
	wire mapped = hit_cfg | hit_cmd | hit_stat;
	wire wr_now = psel & penable & pready_r & pwrite;
	wire cmd_wr = wr_now & hit_cmd;
	wire cmd_arm = cmd_wr & pwdata[TRM_CMD_ARM_BIT];
	wire cmd_exec = cmd_wr & pwdata[TRM_CMD_EXEC_BIT];
	wire cmd_break = cmd_wr & pwdata[TRM_CMD_BREAK_BIT];

	////////////////////////////////////////////////////////////////////////
	// Route decode, one drive and receive flag per pairing.
	logic [TRM_NPAIR-1:0] drv;
	logic [TRM_NPAIR-1:0] rcv;
	genvar gi;
	generate
		for (gi = 0; gi < TRM_NPAIR; gi++) begin : g_pair
			wire [1:0] sel = cfg_r[2*gi+1:2*gi];
			assign drv[gi] = (sel == TRM_ROUTE_DRIVE);
			assign rcv[gi] = (sel == TRM_ROUTE_RECEIVE);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Internal trigger lines.
	wire ana_drv_b = cfg_r[TRM_ANA_DRV_B_BIT];
	wire ana_rcv_b = cfg_r[TRM_ANA_RCV_B_BIT];
	wire brk_b = cfg_r[TRM_BRK_B_BIT];
	wire internal_trigger_a = analyzer_trigger_found
		| (drv[TRM_PAIR_COAX_A] & coax_trigger_line_i)
		| (drv[TRM_PAIR_BUS_A] & bus_cross_trigger_i);
	wire internal_trigger_b = (ana_drv_b & analyzer_trigger_found)
		| (drv[TRM_PAIR_COAX_B] & coax_trigger_line_i)
		| (drv[TRM_PAIR_BUS_B] & bus_cross_trigger_i);
	wire break_line = internal_trigger_a
		| (brk_b & internal_trigger_b);
	wire coax_out = (rcv[TRM_PAIR_COAX_A] & internal_trigger_a)
		| (rcv[TRM_PAIR_COAX_B] & internal_trigger_b);
	wire coax_oe = rcv[TRM_PAIR_COAX_A] | rcv[TRM_PAIR_COAX_B];
	wire bus_out = (rcv[TRM_PAIR_BUS_A] & internal_trigger_a)
		| (rcv[TRM_PAIR_BUS_B] & internal_trigger_b);
	wire bus_oe = rcv[TRM_PAIR_BUS_A] | rcv[TRM_PAIR_BUS_B];

	////////////////////////////////////////////////////////////////////////
	// Run handshake.
	trm_run_e run_state;
	logic run_start;
	logic ready_hold;
	wire break_req = break_line | cmd_break;
	// Own strobe is taken back from the bus so every unit starts on the same edge.
	wire exec_seen = bus_execute_i;

	trm_run_ctl u_run (
		.pclk(pclk),
		.presetn(presetn),
		.arm_req(cmd_arm),
		.exec_seen(exec_seen),
		.bus_ready(bus_ready_i),
		.break_req(break_req),
		.state_r(run_state),
		.start_r(run_start),
		.stop_r(),
		.ready_hold_r(ready_hold)
	);

	wire [31:0] stat_word = {25'h0000000, bus_ready_i, internal_trigger_b, internal_trigger_a,
		run_state == TRM_WAIT_READY, run_state == TRM_RUNNING,
		run_state == TRM_ARMED, run_state == TRM_MONITOR};
	wire [31:0] rd_word = hit_cfg ? {21'h000000, cfg_r} : (hit_stat ? stat_word : TRM_ZERO);

	////////////////////////////////////////////////////////////////////////
	// Registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= TRM_CFG_RST[TRM_CFG_W-1:0];
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= TRM_ZERO;
		end else begin
			pready_r <= setup;
			pslverr_r <= setup & ~mapped;
			prdata_r <= (setup & ~pwrite) ? rd_word : TRM_ZERO;
			if (wr_now && hit_cfg) begin
				cfg_r <= pwdata[TRM_CFG_W-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analyzer_trigger_in <= 1'b0;
			analyzer_start <= 1'b0;
			emulator_break <= 1'b0;
			emulator_start <= 1'b0;
			emulator_running <= 1'b0;
			coax_trigger_line_o <= 1'b0;
			coax_trigger_line_oe <= 1'b0;
			bus_cross_trigger_o <= 1'b0;
			bus_cross_trigger_oe <= 1'b0;
			bus_ready_oe <= 1'b1;
			bus_ready_o <= 1'b0;
			bus_execute_o <= 1'b0;
			bus_execute_oe <= 1'b0;
		end else begin
			analyzer_trigger_in <= ana_rcv_b & internal_trigger_b;
			analyzer_start <= run_start;
			emulator_break <= break_req;
			emulator_start <= run_start;
			emulator_running <= (run_state == TRM_RUNNING);
			coax_trigger_line_o <= coax_out;
			coax_trigger_line_oe <= coax_oe;
			bus_cross_trigger_o <= bus_out;
			bus_cross_trigger_oe <= bus_oe;
			bus_ready_oe <= ready_hold;
			bus_ready_o <= 1'b0;
			bus_execute_o <= cmd_exec;
			bus_execute_oe <= cmd_exec;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
endmodule : trm_matrix
`default_nettype wire

/* File: testbench/trm_matrix_properties.sv */
// Port checker of the trigger routing matrix.
`default_nettype none
module trm_matrix_properties
	import trm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic analyzer_trigger_found,
	input wire logic analyzer_trigger_in,
	input wire logic analyzer_start,
	input wire logic emulator_break,
	input wire logic emulator_start,
	input wire logic emulator_running,
	input wire logic coax_trigger_line_i,
	input wire logic bus_cross_trigger_i,
	input wire logic bus_ready_o,
	input wire logic bus_ready_oe,
	input wire logic bus_execute_o,
	input wire logic bus_execute_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	apb_answer_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	apb_err_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	start_pair_a: assert property (emulator_start == analyzer_start)
		else $error("starts not together");
	found_break_a: assert property (analyzer_trigger_found |=> emulator_break)
		else $error("analyzer trigger gave no break");
	line_src_a: assert property (analyzer_trigger_in |->
		$past(analyzer_trigger_found || coax_trigger_line_i || bus_cross_trigger_i))
		else $error("analyzer triggered without source");
	start_armed_a: assert property (emulator_start |-> !bus_ready_oe)
		else $error("start while ready held");
	break_stop_a: assert property (emulator_break |-> ##[0:2] !emulator_running)
		else $error("break did not stop");
	ready_od_a: assert property (bus_ready_oe |-> !bus_ready_o && !emulator_running)
		else $error("ready driven high");
	exec_pulse_a: assert property ($rose(bus_execute_oe) |-> bus_execute_o ##1 !bus_execute_oe)
		else $error("run strobe too long");
	run_start_a: assert property ($rose(emulator_running) |-> ##[0:1] emulator_start)
		else $error("run without start pulse");
endmodule : trm_matrix_properties
`default_nettype wire

/* File: testbench/trm_peer_model.sv */
// Peer emulator and wired lines of the coordination bus.
`default_nettype none
module trm_peer_model (
	input wire logic peer_armed,
	input wire logic peer_exec,
	input wire logic peer_ct,
	input wire logic bus_ready_o,
	input wire logic bus_ready_oe,
	input wire logic bus_execute_o,
	input wire logic bus_execute_oe,
	input wire logic bus_cross_trigger_o,
	input wire logic bus_cross_trigger_oe,
	output logic bus_ready_i,
	output logic bus_execute_i,
	output logic bus_cross_trigger_i
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pulled up; the peer holds it low until armed and after its own break.
	assign bus_ready_i = !(bus_ready_oe && !bus_ready_o) && peer_armed;
	assign bus_execute_i = (bus_execute_oe && bus_execute_o) || peer_exec;
	assign bus_cross_trigger_i = bus_cross_trigger_oe ? bus_cross_trigger_o : peer_ct;
endmodule : trm_peer_model
`default_nettype wire

/* File: testbench/trm_matrix_tb.sv */
// Register-level testbench of the trigger routing matrix.
`default_nettype none
module trm_matrix_tb
	import trm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic analyzer_trigger_found = 1'h0, coax_ext = 1'h0, err_s;
	logic peer_armed = 1'h0, peer_exec = 1'h0, peer_ct = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, analyzer_trigger_in, analyzer_start, emulator_break;
	logic emulator_start, emulator_running, bus_ready_i, bus_ready_o, bus_ready_oe;
	logic coax_trigger_line_i, coax_trigger_line_o, coax_trigger_line_oe;
	logic bus_cross_trigger_i, bus_cross_trigger_o, bus_cross_trigger_oe;
	logic bus_execute_i, bus_execute_o, bus_execute_oe;
	int n_errors = 0, samples_checked = 0, n_start = 0;
	assign coax_trigger_line_i = coax_trigger_line_oe ? coax_trigger_line_o : coax_ext;
	trm_matrix uut (.*);
	trm_peer_model peer (.*);
	always #50 pclk = ~pclk;
	always @(posedge pclk) if (emulator_start === 1'h1) n_start <= n_start + 1;
	////////////////////////////////////////////////////////////////////////
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		q = prdata;
		err_s = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task chk(input logic [63:0] s, input logic [63:0] x);
		samples_checked++;
		if (s !== x) begin
			n_errors++;
			$display("BAD %0t seen %h want %h", $time, s, x);
		end
	endtask : chk
	task summarize;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3000) @(posedge pclk);
		n_errors++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, TRM_CFG_OFF, 32'h0);
		chk(q, TRM_CFG_RST);
		apb(1'h0, 8'h0c, 32'h0);
		chk({err_s, q}, 33'h1_0000_0000);
		apb(1'h0, TRM_STAT_OFF, 32'h0);
		chk(q[TRM_ST_MONITOR_BIT], 1'h1);
		chk(bus_ready_oe, 1'h1);
		// Coax drives line A.
		apb(1'h1, TRM_CFG_OFF, 32'h201);
		coax_ext <= 1'h1;
		repeat (3) @(posedge pclk);
		chk(emulator_break, 1'h1);
		chk(analyzer_trigger_in, 1'h0);
		coax_ext <= 1'h0;
		repeat (3) @(posedge pclk);
		chk(emulator_break, 1'h0);
		// Bus cross trigger drives line B to the analyzer, break enable off then on.
		apb(1'h1, TRM_CFG_OFF, 32'h240);
		peer_ct <= 1'h1;
		repeat (3) @(posedge pclk);
		chk(analyzer_trigger_in, 1'h1);
		chk(emulator_break, 1'h0);
		apb(1'h1, TRM_CFG_OFF, 32'h640);
		repeat (3) @(posedge pclk);
		chk(emulator_break, 1'h1);
		peer_ct <= 1'h0;
		// Coax receives line A from the analyzer.
		apb(1'h1, TRM_CFG_OFF, 32'h2);
		analyzer_trigger_found <= 1'h1;
		repeat (3) @(posedge pclk);
		chk({coax_trigger_line_oe, coax_trigger_line_o}, 2'h3);
		chk(bus_cross_trigger_oe, 1'h0);
		analyzer_trigger_found <= 1'h0;
		repeat (3) @(posedge pclk);
		chk(coax_trigger_line_o, 1'h0);
		// Bus cross trigger receives line B, driven by the analyzer.
		apb(1'h1, TRM_CFG_OFF, 32'h180);
		analyzer_trigger_found <= 1'h1;
		repeat (3) @(posedge pclk);
		chk({bus_cross_trigger_oe, bus_cross_trigger_o, coax_trigger_line_oe}, 3'h6);
		analyzer_trigger_found <= 1'h0;
		// Run handshake with one peer.
		apb(1'h1, TRM_CFG_OFF, 32'h0);
		apb(1'h1, TRM_CMD_OFF, 32'h1);
		repeat (3) @(posedge pclk);
		chk({bus_ready_oe, bus_ready_i}, 2'h0);
		peer_exec <= 1'h1;
		@(posedge pclk);
		peer_exec <= 1'h0;
		repeat (3) @(posedge pclk);
		chk({n_start, emulator_running}, 33'h0);
		peer_armed <= 1'h1;
		repeat (3) @(posedge pclk);
		chk(bus_ready_i, 1'h1);
		apb(1'h1, TRM_CMD_OFF, 32'h2);
		repeat (4) @(posedge pclk);
		chk({n_start, emulator_running}, 33'h3);
		peer_armed <= 1'h0;
		repeat (3) @(posedge pclk);
		chk(emulator_running, 1'h0);
		peer_armed <= 1'h1;
		repeat (4) @(posedge pclk);
		chk({n_start, emulator_running}, 33'h5);
		apb(1'h1, TRM_CMD_OFF, 32'h4);
		repeat (3) @(posedge pclk);
		chk({emulator_running, bus_ready_i}, 2'h0);
		summarize();
	end
endmodule : trm_matrix_tb
bind trm_matrix trm_matrix_properties chk_i (.*);
`default_nettype wire
